// *** design/nbac_defs.vh ***
`ifndef NBAC_DEFS_VH
`define NBAC_DEFS_VH
// ------------------------------------------------------------
// register offsets (i/o space)
// ------------------------------------------------------------
`define NBAC_ADDR_OFS       6'h1e
`define NBAC_DATA_OFS       6'h1d
`define NBAC_CTRL_OFS       6'h1c
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define NBAC_CTRL_RD_BIT    0
`define NBAC_CTRL_WR_BIT    1
`define NBAC_CTRL_ARM_BIT   2
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define NBAC_ADDR_RST       7'h00
`define NBAC_DATA_RST       8'h00
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define NBAC_ARM_CYCLES     3'd4
`define NBAC_WR_STALL       3'd2
`define NBAC_RD_STALL       3'd4
`define NBAC_CLK_MHZ        250
`define NBAC_WRITE_TIME_US  4000
`define NBAC_WRITE_CYCLES   (`NBAC_WRITE_TIME_US * `NBAC_CLK_MHZ)
`endif

// *** design/nbac_mem.v ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// byte array with registered read data
// ------------------------------------------------------------
module nbac_mem
#(
  parameter ADDR_W = 7,
  parameter DEPTH  = 128
)
(
  input  wire              ref_clk,
  input  wire              clkEn,
  input  wire              wrEn,
  input  wire              rdEn,
  input  wire [ADDR_W-1:0] addr,
  input  wire [7:0]        wrData,
  output reg  [7:0]        rdData
);

  reg [7:0] cellArr [0:DEPTH-1]; // storage cells

  // write and registered read
  always @(posedge ref_clk)
  begin
    if (clkEn)
    begin
      if (wrEn)
        cellArr[addr] <= wrData;
      if (rdEn)
        rdData <= cellArr[addr];
    end
  end

endmodule // nbac_mem

// *** design/nbac_ctrl.v ***
`timescale 1ns/100ps
`include "nbac_defs.vh"

module nbac_ctrl
#(
  parameter WRITE_CYCLES = `NBAC_WRITE_CYCLES,
  parameter ADDR_W       = 7,
  parameter DEPTH        = 128
)
(
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       clkEn,
  input  wire [5:0] ioAddr,
  input  wire       ioWr,
  input  wire       ioRd,
  input  wire [7:0] ioWrData,
  output reg  [7:0] ioRdData,
  output wire       cpuStall,
  output wire       writeBusy
);

  // ------------------------------------------------------------
  // reset synchroniser
  // ------------------------------------------------------------
  reg rstMeta_q;   // first stage
  reg rstSync_q;   // released reset

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  wire rstSync_n = rstSync_q; // active-low internal reset

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire selAddr = ioAddr == `NBAC_ADDR_OFS;    // address register hit
  wire selData = ioAddr == `NBAC_DATA_OFS;    // data register hit
  wire selCtrl = ioAddr == `NBAC_CTRL_OFS;    // control register hit
  wire wrAddr  = clkEn & ioWr & selAddr;      // address write
  wire wrData  = clkEn & ioWr & selData;      // data write
  wire wrCtrl  = clkEn & ioWr & selCtrl;      // control write

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [ADDR_W-1:0] addr_q;   // byte address
  reg [7:0]        data_q;   // data byte
  reg              arm_q;    // write arm bit
  reg [2:0]        armCnt_q; // arm window counter
  reg              wrBusy_q; // write strobe / busy
  reg [31:0]       wrCnt_q;  // self-timed write counter
  reg              rdPend_q; // read data returning
  reg [2:0]        stall_q;  // cpu stall cycles left
  wire [7:0]       memRdData; // memory read data

  wire armSet   = wrCtrl & ioWrData[`NBAC_CTRL_ARM_BIT]
                  & ~ioWrData[`NBAC_CTRL_WR_BIT];
  wire wrLaunch = wrCtrl & ioWrData[`NBAC_CTRL_WR_BIT] & arm_q
                  & ~wrBusy_q;
  wire rdLaunch = wrCtrl & ioWrData[`NBAC_CTRL_RD_BIT];
  wire wrAbort  = wrBusy_q & (wrAddr | wrData);
  wire wrDone   = wrBusy_q & (wrCnt_q == 32'd1);

  // ------------------------------------------------------------
  // address and data registers
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      addr_q <= `NBAC_ADDR_RST;
      data_q <= `NBAC_DATA_RST;
    end
    else if (clkEn)
    begin
      if (wrAddr)
        addr_q <= ioWrData[ADDR_W-1:0];
      // read result takes priority over cpu data write
      if (rdPend_q)
        data_q <= memRdData;
      else if (wrData)
        data_q <= ioWrData;
    end
  end

  // ------------------------------------------------------------
  // arm bit with four-cycle timeout
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      arm_q    <= 1'b0;
      armCnt_q <= 3'h0;
    end
    else if (clkEn)
    begin
      if (armSet)
      begin
        arm_q    <= 1'b1;
        armCnt_q <= `NBAC_ARM_CYCLES;
      end
      else if (arm_q)
      begin
        if (armCnt_q == 3'h1)
          arm_q <= 1'b0;
        armCnt_q <= armCnt_q - 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // self-timed write
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      wrBusy_q <= 1'b0;
      wrCnt_q  <= 32'h0;
    end
    else if (clkEn)
    begin
      if (wrLaunch)
      begin
        wrBusy_q <= 1'b1;
        wrCnt_q  <= WRITE_CYCLES;
      end
      else if (wrAbort | wrDone)
      begin
        wrBusy_q <= 1'b0;
        wrCnt_q  <= 32'h0;
      end
      else if (wrBusy_q)
        wrCnt_q <= wrCnt_q - 32'd1;
    end
  end

  // ------------------------------------------------------------
  // read return and cpu stall
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rdPend_q <= 1'b0;
      stall_q  <= 3'h0;
    end
    else if (clkEn)
    begin
      rdPend_q <= rdLaunch & ~wrBusy_q;
      if (rdLaunch)
        stall_q <= `NBAC_RD_STALL;
      else if (wrLaunch)
        stall_q <= `NBAC_WR_STALL;
      else if (stall_q != 3'h0)
        stall_q <= stall_q - 3'h1;
    end
  end

  assign cpuStall  = stall_q != 3'h0;
  assign writeBusy = wrBusy_q;

  // ------------------------------------------------------------
  // storage array; write lands at launch, abort leaves the new byte in place
  // ------------------------------------------------------------
  nbac_mem
  #(
    .ADDR_W (ADDR_W),
    .DEPTH  (DEPTH)
  )
  u_mem
  (
    .ref_clk (ref_clk),
    .clkEn   (clkEn),
    .wrEn    (wrLaunch),
    .rdEn    (rdLaunch & ~wrBusy_q),
    .addr    (addr_q),
    .wrData  (data_q),
    .rdData  (memRdData)
  );

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      ioRdData <= 8'h00;
    else if (clkEn & ioRd)
    begin
      if (selAddr)
        ioRdData <= {1'b0, addr_q};
      else if (selData)
        ioRdData <= data_q;
      else if (selCtrl)
        ioRdData <= {5'h00, arm_q, wrBusy_q, 1'b0};
      else
        ioRdData <= 8'h00;
    end
  end

endmodule // nbac_ctrl

// *** verification/nbac_ctrl_monitor.sv ***
`timescale 1ns/100ps
module nbac_ctrl_monitor #(parameter WRITE_CYCLES = 20)
(
  input wire       ref_clk,
  input wire       rst_n,
  input wire       clkEn,
  input wire [5:0] ioAddr,
  input wire       ioWr,
  input wire       ioRd,
  input wire [7:0] ioWrData,
  input wire [7:0] ioRdData,
  input wire       cpuStall,
  input wire       writeBusy
);
  wire ctlWr = clkEn && ioWr && ioAddr == 6'h1c; // control write
  wire abtWr = clkEn && ioWr && (ioAddr == 6'h1e || ioAddr == 6'h1d);
  reg [2:0]  armAge_q;  // cycles since arm, saturating
  reg [31:0] busyCnt_q; // cycles busy so far
  // arm age and busy length, in enabled cycles only
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      armAge_q  <= 3'h7;
      busyCnt_q <= 32'h0;
    end
    else if (clkEn)
    begin
      armAge_q  <= (ctlWr && ioWrData[2:1] == 2'b10) ? 3'h0 :
                   armAge_q + {2'h0, armAge_q != 3'h7};
      busyCnt_q <= writeBusy ? busyCnt_q + 32'h1 : 32'h0;
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wr_stall_a: assert property ($rose(writeBusy) |->
    cpuStall[*2] ##1 !cpuStall) else $error("write stall wrong");
  rd_stall_a: assert property (ctlWr && ioWrData == 8'h01 |=>
    cpuStall[*4] ##1 !cpuStall) else $error("read stall wrong");
  strobe_armed_a: assert property (ctlWr && ioWrData == 8'h02 &&
    armAge_q < 3'h4 && !writeBusy |=> writeBusy) else $error("no launch");
  arm_expiry_a: assert property (ctlWr && ioWrData[1] &&
    armAge_q > 3'h3 && !writeBusy |=> !writeBusy) else $error("late launch");
  busy_len_a: assert property ($fell(writeBusy) &&
    !$past(abtWr) |-> busyCnt_q == WRITE_CYCLES)
    else $error("busy length wrong");
  abort_end_a: assert property (writeBusy && abtWr |=>
    !writeBusy) else $error("abort ignored");
  addr_msb_a: assert property (clkEn && ioRd && ioAddr == 6'h1e |=>
    !ioRdData[7]) else $error("address bit 7 set");
  ctrl_read_a: assert property (clkEn && ioRd &&
    ioAddr == 6'h1c |=> ioRdData[7:3] == 5'h00 && !ioRdData[0] &&
    ioRdData[1] == $past(writeBusy)) else $error("control readback wrong");
  cover property (ctlWr && ioWrData == 8'h01);
  cover property ($fell(writeBusy) && !$past(abtWr));
  cover property (writeBusy && abtWr);
endmodule // nbac_ctrl_monitor
bind nbac_ctrl nbac_ctrl_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon_u
  (.ref_clk, .rst_n, .clkEn, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData,
   .cpuStall, .writeBusy);

// *** verification/nbac_cpu.sv ***
`timescale 1ns/100ps
module nbac_cpu
(
  input  wire       ref_clk,
  input  wire       cpuStall,
  input  wire [7:0] ioRdData,
  output reg  [5:0] ioAddr,
  output reg        ioWr,
  output reg        ioRd,
  output reg  [7:0] ioWrData
);
  reg [7:0] stallCnt;  // stall cycles seen after the last write
  reg       stallHang; // stall outlasted the wait bound
  initial
  begin
    stallCnt  = 8'h00;
    stallHang = 1'b0;
    ioAddr   = 6'h00;
    ioWr     = 1'b0;
    ioRd     = 1'b0;
    ioWrData = 8'h00;
  end
  // one i/o write, then sit out a stall of up to 5 cycles
  task wr(input [5:0] a, input [7:0] d);
  begin
    ioAddr   <= a;
    ioWrData <= d;
    ioWr     <= 1'b1;
    @(posedge ref_clk);
    ioWr     <= 1'b0;
    ioAddr   <= ~a; // released lines show garbage
    ioWrData <= ~d;
    stallCnt = 8'h00;
    repeat (6)
    begin
      @(negedge ref_clk);
      if (!cpuStall) break;
      stallCnt = stallCnt + 8'h01;
    end
    // bound used up with the core still held
    if (cpuStall)
      stallHang = 1'b1;
    @(posedge ref_clk);
  end
  endtask
  // one i/o read, data taken the cycle after
  task rd(input [5:0] a, output [7:0] d);
  begin
    ioAddr <= a;
    ioRd   <= 1'b1;
    @(posedge ref_clk);
    ioRd   <= 1'b0;
    ioAddr <= ~a;
    @(negedge ref_clk);
    d = ioRdData;
    @(posedge ref_clk);
  end
  endtask
endmodule // nbac_cpu

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  localparam WC = 20; // short write time
  localparam [0:3][21:0] ROWS = {6'h1e, 8'hff, 8'h7f, 6'h1d, 8'ha5,
    8'ha5, 6'h1c, 8'hf8, 8'h00, 6'h00, 8'hff, 8'h00}; // addr, wr, rd
  reg        ref_clk;
  reg        rst_n;
  reg        clkEn;
  reg  [7:0] rdv;
  integer    errCount;
  integer    checked;
  integer    i;
  wire [5:0] ioAddr;
  wire [7:0] ioWrData;
  wire [7:0] ioRdData;
  wire       ioWr;
  wire       ioRd;
  wire       cpuStall;
  wire       writeBusy;
  always #2 ref_clk = ~ref_clk;
  nbac_ctrl #(.WRITE_CYCLES(WC)) dut_u (.ref_clk, .rst_n, .clkEn,
    .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData, .cpuStall, .writeBusy);
  nbac_cpu cpu_u (.ref_clk, .cpuStall, .ioRdData, .ioAddr, .ioWr, .ioRd,
    .ioWrData);
  // a stall that outlasts the cpu's wait bound ends the run
  always @(posedge cpu_u.stallHang)
  begin
    errCount = errCount + 1;
    complete_run;
  end
  task chk(input [7:0] got, input [7:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      errCount = errCount + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task complete_run;
  begin
    $display("checks %0d errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // bounded wait for the write to finish
  task waitIdle;
    integer n;
  begin
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n = n + 1;
    end while (writeBusy !== 1'b0 && n < 64);
    if (writeBusy !== 1'b0)
    begin
      errCount = errCount + 1;
      complete_run;
    end
    @(posedge ref_clk);
  end
  endtask
  task doReset;
  begin
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  end
  endtask
  // byte write with k+1 idle cycles between arm and strobe
  task launch(input [7:0] a, input [7:0] d, input integer k);
  begin
    cpu_u.wr(6'h1e, a);
    cpu_u.wr(6'h1d, d);
    cpu_u.wr(6'h1c, 8'h04);
    repeat (k) @(posedge ref_clk);
    cpu_u.wr(6'h1c, 8'h02);
  end
  endtask
  task fetch(input [7:0] a, input [7:0] exp);
  begin
    waitIdle;
    cpu_u.wr(6'h1e, a);
    cpu_u.wr(6'h1c, 8'h01);
    chk(cpu_u.stallCnt, 8'h04);
    cpu_u.rd(6'h1d, rdv);
    chk(rdv, exp);
  end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    errCount = 0;
    checked = 0;
    doReset;
    for (i = 0; i < 4; i = i + 1)
    begin
      cpu_u.wr(ROWS[i][21:16], ROWS[i][15:8]);
      cpu_u.rd(ROWS[i][21:16], rdv);
      chk(rdv, ROWS[i][7:0]);
    end
    $display("test registers done");
    launch(8'h7f, 8'h3c, 2);
    chk(cpu_u.stallCnt, 8'h02);
    cpu_u.rd(6'h1c, rdv);
    chk(rdv, 8'h02);
    waitIdle;
    cpu_u.rd(6'h1c, rdv);
    chk(rdv, 8'h00);
    launch(8'h00, 8'hc3, 0);
    cpu_u.wr(6'h1c, 8'h04);
    cpu_u.wr(6'h1c, 8'h02);
    chk(cpu_u.stallCnt, 8'h00);
    fetch(8'h7f, 8'h3c);
    fetch(8'h00, 8'hc3);
    $display("test write done");
    launch(8'h10, 8'h55, 3);
    chk(cpu_u.stallCnt, 8'h00);
    cpu_u.rd(6'h1c, rdv);
    chk(rdv, 8'h00);
    cpu_u.wr(6'h1c, 8'h02);
    cpu_u.rd(6'h1c, rdv);
    chk(rdv, 8'h00);
    launch(8'h20, 8'h66, 1);
    cpu_u.wr(6'h1e, 8'h21);
    cpu_u.rd(6'h1c, rdv);
    chk(rdv, 8'h00);
    $display("test refuse done");
    // arm, then hold the clock enable low past the arm window
    cpu_u.wr(6'h1c, 8'h04);
    clkEn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    clkEn <= 1'b1;
    cpu_u.wr(6'h1c, 8'h02);
    chk(cpu_u.stallCnt, 8'h02);
    cpu_u.rd(6'h1c, rdv);
    chk(rdv, 8'h02);
    waitIdle;
    $display("test freeze done");
    launch(8'h30, 8'h11, 0);
    doReset;
    cpu_u.rd(6'h1e, rdv);
    chk(rdv, 8'h00);
    cpu_u.rd(6'h1d, rdv);
    chk(rdv, 8'h00);
    cpu_u.rd(6'h1c, rdv);
    chk(rdv, 8'h00);
    $display("test reset done");
    complete_run;
  end
endmodule // tb_top
